// ---- verilog/cara_regs.sv ----
// Counter array register access: counter snapshot, channel 0 compare, polarity
// How it works
// - Reading the counter high byte returns the snapshot register, not the live counter.
// - The snapshot loads the counter's upper byte only when the low byte is read.
// - The counter high byte reads as the snapshot; writes pass through as counter bits 15:8.
// - The channel 0 compare low byte holds compare bits 7:0, read/write.
// - With auto-reload select set, the compare low address reaches the reload low byte.
// - With auto-reload select set, the compare high address reaches the reload high byte.
// - The channel 0 compare high byte holds compare bits 15:8.
// - A write to the compare low byte clears the comparator enable.
// - A write to the compare high byte sets the comparator enable.
// - Polarity bits 0..2 invert channel outputs 0..2 when set.
// - A polarity change alters the pin level immediately.
// - With comparator enable low, a counter match has no effect on channel 0.
// - The counter low byte exposes counter bits 7:0 as a read/write field.
`default_nettype none
`include "cara_cfg.svh"
module cara_regs
    import cara_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic sys_rst_in,
    input wire logic [7:0] sfr_addr_in,
    input wire logic sfr_wr_in,
    input wire logic sfr_rd_in,
    input wire logic [7:0] sfr_wdata_in,
    output logic [7:0] sfr_rdata_out,
    input wire logic auto_reload_select_in,
    input wire logic [15:0] counter_in,
    output logic counter_low_wr_out,
    output logic counter_high_wr_out,
    output logic [7:0] counter_wdata_out,
    output logic comparator_enable_out,
    output logic [15:0] ch0_compare_out,
    output logic [15:0] ch0_reload_out,
    output logic ch0_match_out,
    input wire logic [2:0] channel_raw_in,
    output logic channel0_output_out,
    output logic channel1_output_out,
    output logic channel2_output_out
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    cara_sel_t sel;
    always_comb begin
        case (sfr_addr_in)
            `CARA_OFS_POLARITY: sel = CARA_SEL_POL;
            `CARA_OFS_COUNTER_LOW: sel = CARA_SEL_CNT_LOW;
            `CARA_OFS_COUNTER_HIGH: sel = CARA_SEL_CNT_HIGH;
            `CARA_OFS_CH0_CMP_LOW: sel = CARA_SEL_CMP_LOW;
            `CARA_OFS_CH0_CMP_HIGH: sel = CARA_SEL_CMP_HIGH;
            default: sel = CARA_SEL_NONE;
        endcase
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    cara_byte_t snap_q, snap_d;
    cara_byte_t pol_q, pol_d;
    cara_word_t cmp_q, cmp_d;
    cara_word_t rld_q, rld_d;
    logic cmp_en_q, cmp_en_d;
    cara_byte_t rdata_q, rdata_d;
    logic wr_cl, wr_ch;

    assign wr_cl = sfr_wr_in && sel == CARA_SEL_CMP_LOW;
    assign wr_ch = sfr_wr_in && sel == CARA_SEL_CMP_HIGH;

    always_comb begin
        snap_d = snap_q;
        pol_d = pol_q;
        cmp_d = cmp_q;
        rld_d = rld_q;
        cmp_en_d = cmp_en_q;
        if (sfr_rd_in && sel == CARA_SEL_CNT_LOW) begin
            snap_d = counter_in[15:8];
        end
        if (sfr_wr_in && sel == CARA_SEL_POL) begin
            // Reserved bits never stored, so they read as zero
            pol_d = sfr_wdata_in & `CARA_POL_MASK;
        end
        if (wr_cl) begin
            if (auto_reload_select_in) begin
                rld_d[7:0] = sfr_wdata_in;
            end else begin
                cmp_d[7:0] = sfr_wdata_in;
            end
            cmp_en_d = 1'b0;
        end
        if (wr_ch) begin
            if (auto_reload_select_in) begin
                rld_d[15:8] = sfr_wdata_in;
            end else begin
                cmp_d[15:8] = sfr_wdata_in;
            end
            cmp_en_d = 1'b1;
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            snap_q <= `CARA_RST_BYTE;
            pol_q <= `CARA_RST_BYTE;
            cmp_q <= `CARA_RST_WORD;
            rld_q <= `CARA_RST_WORD;
            cmp_en_q <= `CARA_RST_BIT;
        end else begin
            snap_q <= snap_d;
            pol_q <= pol_d;
            cmp_q <= cmp_d;
            rld_q <= rld_d;
            cmp_en_q <= cmp_en_d;
        end
    end

    // ------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------
    // Registered one cycle after the read strobe
    always_comb begin
        rdata_d = `CARA_RST_BYTE;
        if (sfr_rd_in) begin
            case (sel)
                CARA_SEL_POL: rdata_d = pol_q;
                CARA_SEL_CNT_LOW: rdata_d = counter_in[7:0];
                CARA_SEL_CNT_HIGH: rdata_d = snap_q;
                CARA_SEL_CMP_LOW: rdata_d = auto_reload_select_in ? rld_q[7:0] : cmp_q[7:0];
                CARA_SEL_CMP_HIGH: rdata_d = auto_reload_select_in ? rld_q[15:8] : cmp_q[15:8];
                default: rdata_d = `CARA_RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge ref_clk_in) begin
        if (sys_rst_in) begin
            rdata_q <= `CARA_RST_BYTE;
        end else begin
            rdata_q <= rdata_d;
        end
    end

    assign sfr_rdata_out = rdata_q;

    // ------------------------------------------------------------
    // Counter writes pass through to the counter owner
    // ------------------------------------------------------------
    assign counter_low_wr_out = sfr_wr_in && sel == CARA_SEL_CNT_LOW;
    assign counter_high_wr_out = sfr_wr_in && sel == CARA_SEL_CNT_HIGH;
    assign counter_wdata_out = sfr_wdata_in;

    assign comparator_enable_out = cmp_en_q;
    assign ch0_compare_out = cmp_q;
    assign ch0_reload_out = rld_q;
    // Match is gated so a disabled comparator cannot disturb the channel
    assign ch0_match_out = cmp_en_q && counter_in == cmp_q;

    // ------------------------------------------------------------
    // Output polarity, last stage before pin routing
    // ------------------------------------------------------------
    logic [2:0] pins;
    cara_out_stage i_cara_out_stage (
        .raw_in(channel_raw_in),
        .invert_in(pol_q[2:0]),
        .pin_out(pins)
    );
    assign channel0_output_out = pins[0];
    assign channel1_output_out = pins[1];
    assign channel2_output_out = pins[2];

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    property p_snap_read;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        sfr_rd_in && sel == CARA_SEL_CNT_HIGH |=> sfr_rdata_out == $past(snap_q);
    endproperty
    a_snap_read: assert property (p_snap_read) else $error("high byte not snapshot");

    property p_snap_load;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        sfr_rd_in && sel == CARA_SEL_CNT_LOW |=> snap_q == $past(counter_in[15:8]);
    endproperty
    a_snap_load: assert property (p_snap_load) else $error("snapshot not loaded");

    property p_snap_hold;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !(sfr_rd_in && sel == CARA_SEL_CNT_LOW) |=> $stable(snap_q);
    endproperty
    a_snap_hold: assert property (p_snap_hold) else $error("snapshot changed");

    property p_cmp_low;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_cl && !auto_reload_select_in |=> cmp_q[7:0] == $past(sfr_wdata_in) && $stable(rld_q);
    endproperty
    a_cmp_low: assert property (p_cmp_low) else $error("compare low write lost");

    property p_rld_high;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_ch && auto_reload_select_in |=> rld_q[15:8] == $past(sfr_wdata_in) && $stable(cmp_q);
    endproperty
    a_rld_high: assert property (p_rld_high) else $error("reload high write lost");

    property p_cmp_en_clr;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_cl |=> !comparator_enable_out;
    endproperty
    a_cmp_en_clr: assert property (p_cmp_en_clr) else $error("enable not cleared");

    property p_cmp_en_set;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        wr_ch |=> comparator_enable_out;
    endproperty
    a_cmp_en_set: assert property (p_cmp_en_set) else $error("enable not set");

    property p_pol_pin;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        channel0_output_out == (channel_raw_in[0] ^ pol_q[0]) && pol_q[7:3] == 5'h00;
    endproperty
    a_pol_pin: assert property (p_pol_pin) else $error("polarity mismatch");

    property p_match_gate;
        @(posedge ref_clk_in) disable iff (sys_rst_in)
        !comparator_enable_out |-> !ch0_match_out;
    endproperty
    a_match_gate: assert property (p_match_gate) else $error("match while disabled");

    c_snap: cover property (@(posedge ref_clk_in) sfr_rd_in && sel == CARA_SEL_CNT_LOW
        ##1 sfr_rd_in && sel == CARA_SEL_CNT_HIGH);
    c_rld: cover property (@(posedge ref_clk_in) wr_cl && auto_reload_select_in);
    c_cmp_en: cover property (@(posedge ref_clk_in) wr_cl ##1 wr_ch);
    c_match: cover property (@(posedge ref_clk_in) ch0_match_out);
endmodule : cara_regs
`default_nettype wire

// ---- verilog/cara_cfg.svh ----
// Register offsets, field positions and reset values of the counter array slice
`ifndef CARA_CFG_SVH
`define CARA_CFG_SVH

`define CARA_OFS_POLARITY 8'h96
`define CARA_OFS_COUNTER_LOW 8'hf9
`define CARA_OFS_COUNTER_HIGH 8'hfa
`define CARA_OFS_CH0_CMP_LOW 8'hfb
`define CARA_OFS_CH0_CMP_HIGH 8'hfc

`define CARA_RST_BYTE 8'h00
`define CARA_RST_WORD 16'h0000
`define CARA_RST_BIT 1'b0
`define CARA_POL_MASK 8'h07
`define CARA_NUM_CH 3

`endif

// ---- verilog/cara_pkg.sv ----
// Types shared by the counter array register slice
`default_nettype none
package cara_pkg;
    typedef logic [7:0] cara_byte_t;
    typedef logic [15:0] cara_word_t;
    typedef enum logic [2:0] {
        CARA_SEL_NONE,
        CARA_SEL_POL,
        CARA_SEL_CNT_LOW,
        CARA_SEL_CNT_HIGH,
        CARA_SEL_CMP_LOW,
        CARA_SEL_CMP_HIGH
    } cara_sel_t;
endpackage : cara_pkg
`default_nettype wire

// ---- verilog/cara_out_stage.sv ----
// Final per-channel output polarity stage
`default_nettype none
`include "cara_cfg.svh"
module cara_out_stage
    import cara_pkg::*;
(
    input wire logic [`CARA_NUM_CH-1:0] raw_in,
    input wire logic [`CARA_NUM_CH-1:0] invert_in,
    output logic [`CARA_NUM_CH-1:0] pin_out
);
    // ------------------------------------------------------------
    // Inversion
    // ------------------------------------------------------------
    // Combinational so a polarity write shows at the pin at once
    genvar g;
    generate
        for (g = 0; g < `CARA_NUM_CH; g++) begin : g_ch
            assign pin_out[g] = raw_in[g] ^ invert_in[g];
        end
    endgenerate
endmodule : cara_out_stage
`default_nettype wire

// ---- tb/counter_array_register_access_tb_top.sv ----
// Self-checking bench for the counter array register slice
`default_nettype none
module counter_array_register_access_tb_top import cara_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic clk = 1'b0;
    logic rst = 1'b1;
    logic [7:0] addr = 8'h00;
    logic wr_s = 1'b0;
    logic rd_s = 1'b0;
    logic [7:0] wdata = 8'h00;
    logic [7:0] rdata;
    logic ars = 1'b0;
    logic [15:0] cnt = 16'h0000;
    logic [2:0] raw = 3'b101;
    logic cl_wr, ch_wr, en, match;
    logic [7:0] cwd;
    logic [15:0] cmp, rld;
    logic [2:0] outs;
    logic [9:0] cap;
    cara_byte_t d;
    int n_errors = 0;
    int check_count = 0;
    cara_regs i_cara_regs (.ref_clk_in(clk), .sys_rst_in(rst), .sfr_addr_in(addr),
        .sfr_wr_in(wr_s), .sfr_rd_in(rd_s), .sfr_wdata_in(wdata), .sfr_rdata_out(rdata),
        .auto_reload_select_in(ars), .counter_in(cnt), .counter_low_wr_out(cl_wr),
        .counter_high_wr_out(ch_wr), .counter_wdata_out(cwd), .comparator_enable_out(en),
        .ch0_compare_out(cmp), .ch0_reload_out(rld), .ch0_match_out(match),
        .channel_raw_in(raw), .channel0_output_out(outs[0]),
        .channel1_output_out(outs[1]), .channel2_output_out(outs[2]));
    always #5 clk = ~clk;
    // ----------------------------------------
    // Access and compare tasks
    // ----------------------------------------
    task automatic chk_data(input cara_byte_t got, input cara_byte_t exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t data got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_data
    task automatic chk_word(input cara_word_t got, input cara_word_t exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t word got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_word
    task automatic chk_bits(input logic [2:0] got, input logic [2:0] exp);
        check_count++;
        if (got !== exp) begin
            n_errors++;
            $display("ERROR t=%0t bits got=%h exp=%h", $time, got, exp);
        end
    endtask : chk_bits
    // Strobes held across exactly one rising edge
    task automatic rd(input cara_byte_t a, output cara_byte_t v);
        @(negedge clk);
        addr = a;
        rd_s = 1'b1;
        @(negedge clk);
        rd_s = 1'b0;
        v = rdata;
    endtask : rd
    task automatic wr(input cara_byte_t a, input cara_byte_t v);
        @(negedge clk);
        addr = a;
        wdata = v;
        wr_s = 1'b1;
        #1 cap = {cl_wr, ch_wr, cwd};
        @(negedge clk);
        wr_s = 1'b0;
    endtask : wr
    task automatic final_report();
        if (n_errors == 0 && check_count > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask : final_report
    // ----------------------------------------
    // Watchdog at 2000 cycles, far beyond the under 100 cycles needed
    // ----------------------------------------
    initial begin
        #20us;
        n_errors++;
        final_report();
    end
    // ----------------------------------------
    // Test sequence
    // ----------------------------------------
    initial begin
        repeat (12) @(negedge clk);
        rst = 1'b0;
        chk_bits(outs, 3'b101);
        chk_bits({2'b00, en}, 3'b000);
        rd(8'h96, d);
        chk_data(d, 8'h00);
        rd(8'hfb, d);
        chk_data(d, 8'h00);
        rd(8'hfc, d);
        chk_data(d, 8'h00);
        rd(8'h55, d);
        chk_data(d, 8'h00);
        // Snapshot must not follow the live counter between reads
        cnt = 16'h1234;
        rd(8'hf9, d);
        chk_data(d, 8'h34);
        cnt = 16'h5678;
        rd(8'hfa, d);
        chk_data(d, 8'h12);
        rd(8'hfa, d);
        chk_data(d, 8'h12);
        rd(8'hf9, d);
        rd(8'hfa, d);
        chk_data(d, 8'h56);
        wr(8'hf9, 8'h9c);
        chk_word({6'h00, cap}, 16'h029c);
        wr(8'hfa, 8'h3e);
        chk_word({6'h00, cap}, 16'h013e);
        // Enable side effects, high then low write with an idle cycle between
        wr(8'hfc, 8'ha5);
        chk_bits({2'b00, en}, 3'b001);
        wr(8'hfb, 8'h3c);
        chk_bits({2'b00, en}, 3'b000);
        chk_word(cmp, 16'ha53c);
        rd(8'hfb, d);
        chk_data(d, 8'h3c);
        rd(8'hfc, d);
        chk_data(d, 8'ha5);
        cnt = 16'ha53c;
        #1 chk_bits({2'b00, match}, 3'b000);
        wr(8'hfc, 8'ha5);
        chk_bits({2'b00, match}, 3'b001);
        wr(8'hfb, 8'h3c);
        chk_bits({2'b00, match}, 3'b000);
        // Reload alias leaves the compare value alone
        ars = 1'b1;
        wr(8'hfb, 8'h11);
        wr(8'hfc, 8'h22);
        chk_word(rld, 16'h2211);
        chk_word(cmp, 16'ha53c);
        rd(8'hfb, d);
        chk_data(d, 8'h11);
        rd(8'hfc, d);
        chk_data(d, 8'h22);
        ars = 1'b0;
        rd(8'hfb, d);
        chk_data(d, 8'h3c);
        // Polarity takes effect at the rising edge that takes the write
        for (int k = 0; k < 3; k++) begin
            wr(8'h96, 8'h01 << k);
            chk_bits(outs, 3'b101 ^ (3'b001 << k));
        end
        // Reserved polarity bits always written as zero
        wr(8'h96, 8'h07);
        rd(8'h96, d);
        chk_data(d, 8'h07);
        for (int i = 0; i < 8; i++) begin
            @(negedge clk);
            raw = i[2:0];
            #1 chk_bits(outs, i[2:0] ^ 3'b111);
        end
        final_report();
    end
endmodule : counter_array_register_access_tb_top
`default_nettype wire
